// >>> core/ifb_pkg.sv
// Purpose: constants and types for the interrupt flag status bank
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   flag words are 16 bits wide, upper bits read as zero
//
// Summary of operation
// - a flag reads 1 once its source requested, 0 while none pending
// - implemented flags are readable and writable, reset to 0
// - unimplemented bits read 0 and ignore writes
// - flags 0: capture 1 at bit 1, external pin 0 at bit 0
// - flags 1 bits 15..8: uart b tx/rx, pin2, timer5/4, cmp4/3, dma2
// - flags 1 bits 7..5 absent; 4..0 pin1, pin change, cmp1, i2c a
// - flags 2 bits 15..7 absent; 6..0 capture4/3, dma3, can, spi b
// - without the can controller, can flags never signal a request
// - flags 3: quad decoder a bit 10, pwm special match bit 9
// - flags 3: pins 4 and 3 at bits 6,5; i2c b at bits 2,1
// - flags 4: bits 11, 9, 6, 2, 1 only
// - flags 5: pwm gen 2, 1 and adc pair 12 at bits 15..13
// - flags 5 bits 4..1: adc pairs 11, 10, 9, 8 done
// - flags 6: adc pairs 1,0 at 15,14; comparators 4,3,2 at 9..7
// - flags 6 bits 6..0: pwm generators 9 down to 3
// - each source has the same bit in its flag and enable registers
// - a set flag reaches the cpu only while its enable bit is 1
package ifb_pkg;
  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned FLAG_W   = 16;

  // byte addresses: flags at 0x00.., enables at 0x20..
  localparam logic [7:0] FLAGS_BASE  = 8'h00;
  localparam logic [7:0] ENABLE_BASE = 8'h20;
  localparam logic [7:0] PEND_ADDR   = 8'h40;

  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] EN_RESET   = 16'h0000;

  // implemented bit masks per flag register
  localparam logic [15:0] IMPL_MASK0 = 16'h0003;
  localparam logic [15:0] IMPL_MASK1 = 16'hFF1F;
  localparam logic [15:0] IMPL_MASK2 = 16'h007F;
  localparam logic [15:0] IMPL_MASK3 = 16'h0666;
  localparam logic [15:0] IMPL_MASK4 = 16'h0A46;
  localparam logic [15:0] IMPL_MASK5 = 16'hE01E;
  localparam logic [15:0] IMPL_MASK6 = 16'hC3FF;

  // can related bits: reg2 bits 3,2 and reg4 bit 6
  localparam logic [15:0] CAN_MASK2 = 16'h000C;
  localparam logic [15:0] CAN_MASK4 = 16'h0040;

  typedef logic [NUM_REGS-1:0][FLAG_W-1:0] ifb_bank_type;

  typedef struct packed {
    ifb_bank_type flags;
    ifb_bank_type enables;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
  } ifb_state_type;
endpackage

// >>> core/ifb_bank.sv
// Purpose: interrupt request flag bank with enables, apb access
// Assumes: event lines are one-cycle or level requests on pclk
// Notes:   zero wait-state apb slave; unmapped addresses error
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module ifb_bank #(
  parameter bit HAS_CAN = 1'b1
) (
  // apb
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // peripheral events, one vector per flag register
  input  wire ifb_pkg::ifb_bank_type event_in,
  // to cpu arbitration
  output ifb_pkg::ifb_bank_type      pending,
  output logic                       irq
);
  localparam ifb_pkg::ifb_bank_type CAN_ALL =
    {16'h0000, 16'h0000, ifb_pkg::CAN_MASK4, 16'h0000,
     ifb_pkg::CAN_MASK2, 16'h0000, 16'h0000};
  localparam ifb_pkg::ifb_bank_type IMPL_ALL =
    {ifb_pkg::IMPL_MASK6, ifb_pkg::IMPL_MASK5, ifb_pkg::IMPL_MASK4,
     ifb_pkg::IMPL_MASK3, ifb_pkg::IMPL_MASK2, ifb_pkg::IMPL_MASK1,
     ifb_pkg::IMPL_MASK0};
  // can flags removed when the controller is absent
  localparam ifb_pkg::ifb_bank_type LIVE =
    HAS_CAN ? IMPL_ALL : (IMPL_ALL & ~CAN_ALL);

  ifb_pkg::ifb_state_type state;
  ifb_pkg::ifb_state_type next_state;

  logic        access;
  logic        wr_en;
  logic        flag_hit;
  logic        en_hit;
  logic        pend_hit;
  logic [2:0]  idx;
  logic [15:0] wmask;

  always_comb begin
    access   = psel && penable;
    idx      = paddr[4:2];
    flag_hit = (paddr[7:5] == ifb_pkg::FLAGS_BASE[7:5]) &&
               (idx < 3'(ifb_pkg::NUM_REGS)) && (paddr[1:0] == 2'h0);
    en_hit   = (paddr[7:5] == ifb_pkg::ENABLE_BASE[7:5]) &&
               (idx < 3'(ifb_pkg::NUM_REGS)) && (paddr[1:0] == 2'h0);
    pend_hit = (paddr == ifb_pkg::PEND_ADDR);
    wr_en    = access && pwrite;
    wmask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  always_comb begin
    next_state         = state;
    next_state.pready  = psel && !penable;
    next_state.pslverr = 1'b0;
    next_state.prdata  = 32'h0000_0000;
    for (int i = 0; i < ifb_pkg::NUM_REGS; i++) begin
      // software write stores 0 or 1 per lane
      if (wr_en && flag_hit && (idx == 3'(i))) begin
        next_state.flags[i] = (state.flags[i] & ~wmask) |
                              (pwdata[15:0] & wmask);
      end
      if (wr_en && en_hit && (idx == 3'(i))) begin
        next_state.enables[i] = (state.enables[i] & ~wmask) |
                                (pwdata[15:0] & wmask);
      end
      // hardware set wins over a same-cycle clear
      next_state.flags[i] = (next_state.flags[i] | event_in[i])
                            & LIVE[i];
      next_state.enables[i] = next_state.enables[i] & LIVE[i];
    end
    if (psel && !penable) begin
      if (flag_hit) begin
        next_state.prdata = {16'h0000, state.flags[idx]};
      end else if (en_hit) begin
        next_state.prdata = {16'h0000, state.enables[idx]};
      end else if (pend_hit) begin
        next_state.prdata = {24'h00_0000, 1'b0, 7'(pending_any())};
      end else begin
        next_state.pslverr = 1'b1;
      end
      if (pwrite && pend_hit) begin
        next_state.pslverr = 1'b1;
      end
    end
  end

  function automatic logic [6:0] pending_any();
    logic [6:0] r;
    r = 7'h00;
    for (int j = 0; j < ifb_pkg::NUM_REGS; j++) begin
      r[j] = |(state.flags[j] & state.enables[j]);
    end
    return r;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.flags   <= {ifb_pkg::NUM_REGS{ifb_pkg::FLAG_RESET}};
      state.enables <= {ifb_pkg::NUM_REGS{ifb_pkg::EN_RESET}};
      state.pready  <= 1'b0;
      state.prdata  <= 32'h0000_0000;
      state.pslverr <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign pready  = state.pready;
  assign prdata  = state.prdata;
  assign pslverr = state.pslverr;
  assign pending = state.flags & state.enables;
  assign irq     = |pending;

  a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (event_in[0][0]) |=> state.flags[0][0])
    else $error("event did not set flag");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (state.flags & ~LIVE) == '0)
    else $error("unimplemented flag bit set");
  a_irq_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> |(state.flags & state.enables))
    else $error("irq without enabled flag");
  a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (state.flags[1][4] && !(wr_en && flag_hit)) |=> state.flags[1][4])
    else $error("flag dropped without write");
  a_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h6 && pstrb[1] && pwdata[15])
    |=> state.flags[6][15])
    else $error("software set lost");
  a_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h5 && pstrb[1] && !pwdata[15]
     && !event_in[5][15]) |=> !state.flags[5][15])
    else $error("software clear lost");
  a_can_absent: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_CAN |-> ((state.flags & CAN_ALL) == '0))
    else $error("can flag set on can-less part");
  a_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

  a_mask_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[0] & ~LIVE[0]) == 16'h0000))
    else $error("flags 0 bad bit");
  a_en_mask_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[0] & ~LIVE[0]) == 16'h0000))
    else $error("enables 0 bad bit");
  a_sw_set_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h0) |=>
    ((~state.flags[0] & $past(pwdata[15:0] & wmask) & LIVE[0]) == 16'h0000))
    else $error("flags 0 set lost");
  a_evt_set_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[0] != 16'h0000) |=>
    ((~state.flags[0] & $past(event_in[0]) & LIVE[0]) == 16'h0000))
    else $error("flags 0 event lost");
  a_hold_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h0) |=>
    ((~state.flags[0] & $past(state.flags[0])) == 16'h0000))
    else $error("flags 0 dropped");
  a_sw_clear_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h0) |=> ((state.flags[0] &
    $past(wmask & ~pwdata[15:0] & ~event_in[0])) == 16'h0000))
    else $error("flags 0 clear lost");
  a_read_r0: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h0) |=>
    (prdata == {16'h0000, $past(state.flags[0])}))
    else $error("flags 0 read wrong");

  a_mask_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[1] & ~LIVE[1]) == 16'h0000))
    else $error("flags 1 bad bit");
  a_en_mask_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[1] & ~LIVE[1]) == 16'h0000))
    else $error("enables 1 bad bit");
  a_sw_set_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h1) |=>
    ((~state.flags[1] & $past(pwdata[15:0] & wmask) & LIVE[1]) == 16'h0000))
    else $error("flags 1 set lost");
  a_evt_set_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[1] != 16'h0000) |=>
    ((~state.flags[1] & $past(event_in[1]) & LIVE[1]) == 16'h0000))
    else $error("flags 1 event lost");
  a_hold_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h1) |=>
    ((~state.flags[1] & $past(state.flags[1])) == 16'h0000))
    else $error("flags 1 dropped");
  a_sw_clear_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h1) |=> ((state.flags[1] &
    $past(wmask & ~pwdata[15:0] & ~event_in[1])) == 16'h0000))
    else $error("flags 1 clear lost");
  a_read_r1: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h1) |=>
    (prdata == {16'h0000, $past(state.flags[1])}))
    else $error("flags 1 read wrong");

  a_mask_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[2] & ~LIVE[2]) == 16'h0000))
    else $error("flags 2 bad bit");
  a_en_mask_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[2] & ~LIVE[2]) == 16'h0000))
    else $error("enables 2 bad bit");
  a_sw_set_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h2) |=>
    ((~state.flags[2] & $past(pwdata[15:0] & wmask) & LIVE[2]) == 16'h0000))
    else $error("flags 2 set lost");
  a_evt_set_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[2] != 16'h0000) |=>
    ((~state.flags[2] & $past(event_in[2]) & LIVE[2]) == 16'h0000))
    else $error("flags 2 event lost");
  a_hold_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h2) |=>
    ((~state.flags[2] & $past(state.flags[2])) == 16'h0000))
    else $error("flags 2 dropped");
  a_sw_clear_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h2) |=> ((state.flags[2] &
    $past(wmask & ~pwdata[15:0] & ~event_in[2])) == 16'h0000))
    else $error("flags 2 clear lost");
  a_read_r2: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h2) |=>
    (prdata == {16'h0000, $past(state.flags[2])}))
    else $error("flags 2 read wrong");

  a_mask_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[3] & ~LIVE[3]) == 16'h0000))
    else $error("flags 3 bad bit");
  a_en_mask_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[3] & ~LIVE[3]) == 16'h0000))
    else $error("enables 3 bad bit");
  a_sw_set_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h3) |=>
    ((~state.flags[3] & $past(pwdata[15:0] & wmask) & LIVE[3]) == 16'h0000))
    else $error("flags 3 set lost");
  a_evt_set_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[3] != 16'h0000) |=>
    ((~state.flags[3] & $past(event_in[3]) & LIVE[3]) == 16'h0000))
    else $error("flags 3 event lost");
  a_hold_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h3) |=>
    ((~state.flags[3] & $past(state.flags[3])) == 16'h0000))
    else $error("flags 3 dropped");
  a_sw_clear_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h3) |=> ((state.flags[3] &
    $past(wmask & ~pwdata[15:0] & ~event_in[3])) == 16'h0000))
    else $error("flags 3 clear lost");
  a_read_r3: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h3) |=>
    (prdata == {16'h0000, $past(state.flags[3])}))
    else $error("flags 3 read wrong");

  a_mask_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[4] & ~LIVE[4]) == 16'h0000))
    else $error("flags 4 bad bit");
  a_en_mask_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[4] & ~LIVE[4]) == 16'h0000))
    else $error("enables 4 bad bit");
  a_sw_set_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h4) |=>
    ((~state.flags[4] & $past(pwdata[15:0] & wmask) & LIVE[4]) == 16'h0000))
    else $error("flags 4 set lost");
  a_evt_set_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[4] != 16'h0000) |=>
    ((~state.flags[4] & $past(event_in[4]) & LIVE[4]) == 16'h0000))
    else $error("flags 4 event lost");
  a_hold_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h4) |=>
    ((~state.flags[4] & $past(state.flags[4])) == 16'h0000))
    else $error("flags 4 dropped");
  a_sw_clear_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h4) |=> ((state.flags[4] &
    $past(wmask & ~pwdata[15:0] & ~event_in[4])) == 16'h0000))
    else $error("flags 4 clear lost");
  a_read_r4: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h4) |=>
    (prdata == {16'h0000, $past(state.flags[4])}))
    else $error("flags 4 read wrong");

  a_mask_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[5] & ~LIVE[5]) == 16'h0000))
    else $error("flags 5 bad bit");
  a_en_mask_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[5] & ~LIVE[5]) == 16'h0000))
    else $error("enables 5 bad bit");
  a_sw_set_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h5) |=>
    ((~state.flags[5] & $past(pwdata[15:0] & wmask) & LIVE[5]) == 16'h0000))
    else $error("flags 5 set lost");
  a_evt_set_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[5] != 16'h0000) |=>
    ((~state.flags[5] & $past(event_in[5]) & LIVE[5]) == 16'h0000))
    else $error("flags 5 event lost");
  a_hold_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h5) |=>
    ((~state.flags[5] & $past(state.flags[5])) == 16'h0000))
    else $error("flags 5 dropped");
  a_sw_clear_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h5) |=> ((state.flags[5] &
    $past(wmask & ~pwdata[15:0] & ~event_in[5])) == 16'h0000))
    else $error("flags 5 clear lost");
  a_read_r5: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h5) |=>
    (prdata == {16'h0000, $past(state.flags[5])}))
    else $error("flags 5 read wrong");

  a_mask_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.flags[6] & ~LIVE[6]) == 16'h0000))
    else $error("flags 6 bad bit");
  a_en_mask_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((state.enables[6] & ~LIVE[6]) == 16'h0000))
    else $error("enables 6 bad bit");
  a_sw_set_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h6) |=>
    ((~state.flags[6] & $past(pwdata[15:0] & wmask) & LIVE[6]) == 16'h0000))
    else $error("flags 6 set lost");
  a_evt_set_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in[6] != 16'h0000) |=>
    ((~state.flags[6] & $past(event_in[6]) & LIVE[6]) == 16'h0000))
    else $error("flags 6 event lost");
  a_hold_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && flag_hit && idx == 3'h6) |=>
    ((~state.flags[6] & $past(state.flags[6])) == 16'h0000))
    else $error("flags 6 dropped");
  a_sw_clear_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && flag_hit && idx == 3'h6) |=> ((state.flags[6] &
    $past(wmask & ~pwdata[15:0] & ~event_in[6])) == 16'h0000))
    else $error("flags 6 clear lost");
  a_read_r6: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && flag_hit && idx == 3'h6) |=>
    (prdata == {16'h0000, $past(state.flags[6])}))
    else $error("flags 6 read wrong");
endmodule

// >>> test/ifb_src.sv
// Purpose: model of the peripheral event sources
// Assumes: bench requests one-cycle pulses on ev
// Notes:   lines sit low between requests
`timescale 1ns/10ps
module ifb_src (
  // clock and event lines
  input  wire logic                  pclk,
  input  wire ifb_pkg::ifb_bank_type ev,
  output ifb_pkg::ifb_bank_type      event_in
);
  always @(posedge pclk) event_in <= ev;
endmodule

// >>> test/ifb_bank_tb.sv
// Purpose: self-checking bench for the flag bank
// Assumes: zero wait-state apb slave, one clock
// Notes:   can bits present, events from ifb_src
`timescale 1ns/10ps
module ifb_bank_tb;
  logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, err;
  logic                  penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [3:0]            pstrb = 4'h0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, rd, prdata;
  ifb_pkg::ifb_bank_type ev = '0, event_in, pending;
  int                    failures = 0, checks = 0;
  localparam logic [15:0] MASK [7] = '{ifb_pkg::IMPL_MASK0,
    ifb_pkg::IMPL_MASK1, ifb_pkg::IMPL_MASK2, ifb_pkg::IMPL_MASK3,
    ifb_pkg::IMPL_MASK4, ifb_pkg::IMPL_MASK5, ifb_pkg::IMPL_MASK6};
  always #4 pclk = ~pclk;
  ifb_bank #(.HAS_CAN(1'b1)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .event_in(event_in), .pending(pending), .irq(irq));
  ifb_src src (.pclk(pclk), .ev(ev), .event_in(event_in));
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) $display("BAD %s exp %h got %h", s, e, g);
    if (g !== e) failures++;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, pwrite, pstrb, paddr, pwdata} <= {1'b1, w, {4{w}}, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    if (n >= 16) failures++;
    if (n >= 16) tally_and_finish();
  endtask
  // one-cycle request on register i, released next edge
  task automatic pulse(input int i, input logic [15:0] b);
    @(posedge pclk);
    ev[i] <= b;
    @(posedge pclk);
    ev <= '0;
  endtask
  task automatic t_rw();
    for (int i = 0; i < 7; i++) begin
      apb(0, ifb_pkg::FLAGS_BASE + 8'(4 * i), 0);
      chk("reset value", 32'h0, rd);
      apb(1, ifb_pkg::FLAGS_BASE + 8'(4 * i), 32'hFFFFFFFF);
      apb(0, ifb_pkg::FLAGS_BASE + 8'(4 * i), 0);
      chk("written ones", {16'h0000, MASK[i]}, rd);
      apb(1, ifb_pkg::FLAGS_BASE + 8'(4 * i), 0);
    end
  endtask
  task automatic t_irq();
    pulse(3, 16'h0400);
    #20;
    chk("irq while disabled", 32'h0, {31'h0, irq});
    apb(1, ifb_pkg::ENABLE_BASE + 8'h0C, 32'h0000FFFF);
    #1;
    chk("irq enabled", 32'h1, {31'h0, irq});
    chk("pending word", 32'h0400, {16'h0000, pending[3]});
  endtask
  task automatic t_bad();
    apb(1, ifb_pkg::PEND_ADDR, 32'h0000FFFF);
    chk("refused write", 32'h1, {31'h0, err});
    apb(0, ifb_pkg::PEND_ADDR, 0);
    chk("pending summary", 32'h8, rd);
  endtask
  task automatic t_evt();
    for (int i = 0; i < 7; i++) begin
      pulse(i, 16'hFFFF);
      apb(0, ifb_pkg::FLAGS_BASE + 8'(4 * i), 0);
      chk("event flags", {16'h0000, MASK[i]}, rd);
    end
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_rw();
    t_irq();
    t_bad();
    t_evt();
    tally_and_finish();
  end
endmodule
